/* sim/tb_ulw_lin_guard.sv */
// self-checking bench of the lin/guard block
`timescale 1ns/1ps
`include "ulw_params.svh"
module tb_ulw_lin_guard;
  localparam logic [31:0] VER = 32'h00000abc; // arbitrary value
  logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, ck_clear_i, send_q, err_q;
  logic rx_id_valid_i, pready_o, pslverr_o, lin_master_o, tx_resp_o, rx_resp_o;
  logic chk_en_o, chk_classic_o, rx_timeout_o, div_tick_o, id_perr_o;
  logic [7:0]  paddr_i, sid_q, rx_id_i, id_tx_o, checksum_o, guard_time_o;
  logic [31:0] pwdata_i, prdata_o, rd_q;
  logic [8:0]  resp_len_o;
  logic [15:0] cd_o;
  logic [2:0]  fp_o;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  ulw_lin_guard #(.VERSION_ID(VER)) ulw_lin_guard_i (.ck_valid_i(1'b0), .ck_data_i(8'h00),
    .bit_tick_i(1'b0), .rx_active_i(1'b0), .*);
  ulw_lin_node ulw_lin_node_i (.mclk_i(mclk_i), .send_i(send_q), .id_i(sid_q),
    .valid_o(rx_id_valid_i), .id_o(rx_id_i));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic seed(logic [7:0] exp);
    @(posedge mclk_i);
    ck_clear_i <= 1'b1;
    @(posedge mclk_i);
    ck_clear_i <= 1'b0;
    @(negedge mclk_i);
    chk("seed", checksum_o, exp);
  endtask
  task automatic t_reset;
    xfer(0, `ULW_OFF_VER, 0);
    chk("version", rd_q, VER);
    xfer(0, `ULW_OFF_WRITE_GUARD_MODE, 0);
    chk("guard mode", rd_q, 0);
    xfer(0, `ULW_OFF_LIN_FRAME_IDENTIFIER, 0);
    chk("identifier", rd_q, 0);
    xfer(0, 8'h80, 0);
    chk("unmapped", err_q, 1);
  endtask
  task automatic t_guard;
    xfer(1, `ULW_OFF_MODE, 1);
    xfer(1, `ULW_OFF_RX_TIMEOUT_REGISTER, 32'hffffffff);
    xfer(0, `ULW_OFF_RX_TIMEOUT_REGISTER, 0);
    chk("timeout", rd_q, 32'h0001ffff);
    xfer(1, `ULW_OFF_WRITE_GUARD_MODE, 32'h00000001);
    xfer(0, `ULW_OFF_WRITE_GUARD_MODE, 0);
    chk("bad key", rd_q, 0);
    xfer(1, `ULW_OFF_WRITE_GUARD_MODE, 32'h55534101 + 32'h00000200);
    xfer(1, `ULW_OFF_WRITE_GUARD_MODE, {24'h555341, 8'h01});
    xfer(0, `ULW_OFF_WRITE_GUARD_MODE, 0);
    chk("guard on", rd_q, 1);
    xfer(1, `ULW_OFF_BRGR, 32'h00012345);
    chk("divider kept", cd_o, 0);
    xfer(1, `ULW_OFF_TTGR, 32'h5a);
    xfer(0, `ULW_OFF_WRITE_GUARD_STATUS, 0);
    chk("violation", rd_q, 32'h00002801);
    xfer(0, `ULW_OFF_WRITE_GUARD_STATUS, 0);
    chk("cleared", rd_q, 0);
    xfer(1, `ULW_OFF_MODE, 0);
    chk("mode kept", lin_master_o, 1);
    xfer(1, `ULW_OFF_WRITE_GUARD_MODE, {24'h555341, 8'h00});
    xfer(1, `ULW_OFF_BRGR, 32'h00012345);
    xfer(1, `ULW_OFF_TTGR, 32'h5a);
    chk("divider", {fp_o, cd_o, guard_time_o}, 32'h0123455a);
  endtask
  task automatic t_lin;
    xfer(1, `ULW_OFF_LIN_FRAME_IDENTIFIER, 32'h35);
    chk("id parity", id_tx_o, 8'hf5);
    xfer(1, `ULW_OFF_LINMR, 32'h04);
    chk("id raw", id_tx_o, 8'h35);
    xfer(1, `ULW_OFF_LINMR, 32'hff00);
    chk("len max", resp_len_o, 256);
    xfer(1, `ULW_OFF_LINMR, 32'hff20);
    chk("len id", resp_len_o, 8);
    for (int i = 0; i < 4; i++) begin
      xfer(1, `ULW_OFF_LINMR, i | 32'h18);
      chk("action", {tx_resp_o, rx_resp_o}, {i == 0, i == 1});
    end
    chk("kind off", {chk_en_o, chk_classic_o}, 2'b01);
    seed(8'hff);
    xfer(1, `ULW_OFF_LINMR, 0);
    chk("len min", {chk_en_o, chk_classic_o, resp_len_o}, 11'h401);
    seed(8'h0a);
  endtask
  task automatic t_slave;
    xfer(1, `ULW_OFF_MODE, 0);
    @(posedge mclk_i);
    sid_q  <= 8'h2a;
    send_q <= 1'b1;
    @(posedge mclk_i);
    send_q <= 1'b0;
    xfer(1, `ULW_OFF_LIN_FRAME_IDENTIFIER, 32'h11);
    xfer(0, `ULW_OFF_LIN_FRAME_IDENTIFIER, 0);
    chk("rx id", rd_q[5:0], 6'h2a);
    chk("rx id parity", id_perr_o, 1);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compared", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, ck_clear_i, send_q} = 5'h00;
    {paddr_i, sid_q, pwdata_i} = 48'h0;
    nrst_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_guard;
    t_lin;
    t_slave;
    tally_and_finish;
  end
endmodule

/* sim/ulw_lin_guard_assertions.sv */
// port-level checks of the lin/guard block
`timescale 1ns/1ps
`include "ulw_params.svh"
module ulw_lin_guard_chk #(
  parameter logic [31:0] VERSION_ID = `ULW_VERSION // arbitrary value
) (
  input wire logic        mclk_i,        // clock
  input wire logic        nrst_i,        // reset
  input wire logic        psel_i,        // select
  input wire logic        penable_i,     // enable
  input wire logic        pwrite_i,      // write
  input wire logic [7:0]  paddr_i,       // address
  input wire logic [31:0] pwdata_i,      // wdata
  input wire logic [31:0] prdata_o,      // rdata
  input wire logic        pready_o,      // ready
  input wire logic        lin_master_o,  // master
  input wire logic [7:0]  id_tx_o,       // id out
  input wire logic        rx_id_valid_i, // id strobe
  input wire logic [7:0]  rx_id_i,       // id in
  input wire logic        tx_resp_o,     // sends
  input wire logic        rx_resp_o,     // receives
  input wire logic        chk_classic_o, // classic
  input wire logic        ck_clear_i,    // seed
  input wire logic [7:0]  checksum_o,    // sum
  input wire logic        div_tick_o     // tick
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rd(a);
    psel_i && penable_i && pready_o && !pwrite_i && paddr_i == a;
  endsequence
  sequence s_wr(a);
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
  endsequence
  property p_div;
    div_tick_o |=> !div_tick_o [*7] ##1 div_tick_o;
  endproperty
  a_div: assert property (p_div) else $error("divided tick spacing wrong");
  property p_key;
    s_rd(`ULW_OFF_WRITE_GUARD_MODE) |-> prdata_o[31:8] == 24'h000000;
  endproperty
  a_key: assert property (p_key) else $error("key field not zero");
  property p_ver;
    s_rd(`ULW_OFF_VER) |-> prdata_o == VERSION_ID;
  endproperty
  a_ver: assert property (p_ver) else $error("version value wrong");
  property p_to;
    s_rd(`ULW_OFF_RX_TIMEOUT_REGISTER) |-> prdata_o[31:17] == 15'h0000;
  endproperty
  a_to: assert property (p_to) else $error("timeout field too wide");
  property p_node_action;
    !(tx_resp_o && rx_resp_o);
  endproperty
  a_node_action: assert property (p_node_action) else $error("send and receive together");
  property p_mst;
    s_wr(`ULW_OFF_LIN_FRAME_IDENTIFIER) ##0 lin_master_o |=> id_tx_o[5:0] == $past(pwdata_i[5:0]);
  endproperty
  a_mst: assert property (p_mst) else $error("master id not sent");
  property p_slv;
    !lin_master_o && rx_id_valid_i |=> id_tx_o[5:0] == $past(rx_id_i[5:0]);
  endproperty
  a_slv: assert property (p_slv) else $error("received id not held");
  property p_seed;
    ck_clear_i |=> checksum_o == ($past(chk_classic_o) ? 8'hff : ~$past(id_tx_o));
  endproperty
  a_seed: assert property (p_seed) else $error("checksum seed wrong");
endmodule
bind ulw_lin_guard ulw_lin_guard_chk #(.VERSION_ID(VERSION_ID)) chk_i (.*);

/* sim/ulw_lin_node.sv */
// remote lin node: sends a frame identifier on request
`timescale 1ns/1ps
module ulw_lin_node (
  input  wire logic       mclk_i,  // clock
  input  wire logic       send_i,  // send one id
  input  wire logic [7:0] id_i,    // id to send
  output logic            valid_o, // id strobe
  output logic [7:0]      id_o     // id, toggling off frame
);
  logic       v_q = 1'b0;
  logic [7:0] d_q = 8'h00;
  // off frame the line flips each cycle so stale data cannot pass
  always @(posedge mclk_i) begin
    v_q <= send_i;
    d_q <= send_i ? id_i : ~d_q;
  end
  assign valid_o = v_q;
  assign id_o    = d_q;
endmodule

/* src/ulw_lin_guard.sv */
// lin frame options, identifier, write guard, version and divided clock tick
`timescale 1ns/1ps
`include "ulw_params.svh"
module ulw_lin_guard #(
  parameter logic [31:0] VERSION_ID = `ULW_VERSION // arbitrary value
) (
  input  wire logic        mclk_i,        // 25 mhz module clock
  input  wire logic        nrst_i,        // async reset, active low
  input  wire logic        psel_i,        // apb select
  input  wire logic        penable_i,     // apb enable
  input  wire logic        pwrite_i,      // apb write
  input  wire logic [7:0]  paddr_i,       // apb byte address
  input  wire logic [31:0] pwdata_i,      // apb write data
  output logic      [31:0] prdata_o,      // apb read data
  output logic             pready_o,      // apb ready
  output logic             pslverr_o,     // apb unmapped address
  output logic             lin_master_o,  // lin master role selected
  output logic [7:0]       id_tx_o,       // identifier to transmit
  input  wire logic        rx_id_valid_i, // received identifier strobe
  input  wire logic [7:0]  rx_id_i,       // received identifier
  output logic             id_perr_o,     // received id parity bad
  output logic [8:0]       resp_len_o,    // response length in bytes
  output logic             tx_resp_o,     // node sends response
  output logic             rx_resp_o,     // node receives response
  output logic             chk_en_o,      // checksum generate/check
  output logic             chk_classic_o, // classic checksum selected
  input  wire logic        ck_clear_i,    // start new checksum
  input  wire logic        ck_valid_i,    // data byte strobe
  input  wire logic [7:0]  ck_data_i,     // data byte
  output logic [7:0]       checksum_o,    // checksum of bytes so far
  input  wire logic        bit_tick_i,    // one pulse per bit period
  input  wire logic        rx_active_i,   // receiver saw activity
  output logic             rx_timeout_o,  // timeout pulse
  output logic             div_tick_o,    // divided clock tick
  output logic [15:0]      cd_o,          // baud clock divider
  output logic [2:0]       fp_o,          // baud fractional part
  output logic [7:0]       guard_time_o   // transmit guard time
);

  ulw_pkg::ulw_state_s s_q;
  ulw_pkg::ulw_state_s s_d;
  ulw_pkg::ulw_node_action_e  node_action;

  logic        acc;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic        guarded;
  logic [31:0] rmux;
  logic        hit;
  logic        master;
  logic [7:0]  prot_id;
  logic [7:0]  id_len;
  logic [8:0]  sum9;
  logic [1:0]  rx_par;

  assign master = s_q.mode[`ULW_MR_LINM];
  assign node_action = ulw_pkg::ulw_node_action_e'(s_q.linmr[`ULW_LM_NODE_ACTION_HI:`ULW_LM_NODE_ACTION_LO]);

  // apb answers one cycle into the access phase so read data is a flop
  assign acc = psel_i & penable_i;
  assign done = acc & s_q.rdy;
  assign wr_done = done & pwrite_i;
  assign rd_done = done & ~pwrite_i;

  // mode, divider, timeout and guard time sit behind the guard
  always_comb begin
    case (paddr_i)
      `ULW_OFF_MODE,
      `ULW_OFF_BRGR,
      `ULW_OFF_RX_TIMEOUT_REGISTER,
      `ULW_OFF_TTGR: guarded = 1'b1;
      default:       guarded = 1'b0;
    endcase
  end

  // identifier with parity bits in 7:6 unless parity is off
  always_comb begin
    prot_id = s_q.lin_frame_identifier;
    if (!s_q.linmr[`ULW_LM_ID_PARITY_OFF]) begin
      prot_id[6] = s_q.lin_frame_identifier[0] ^ s_q.lin_frame_identifier[1] ^ s_q.lin_frame_identifier[2] ^ s_q.lin_frame_identifier[4];
      prot_id[7] = ~(s_q.lin_frame_identifier[1] ^ s_q.lin_frame_identifier[3] ^ s_q.lin_frame_identifier[4] ^ s_q.lin_frame_identifier[5]);
    end
  end

  assign rx_par[0] = rx_id_i[0] ^ rx_id_i[1] ^ rx_id_i[2] ^ rx_id_i[4];
  assign rx_par[1] = ~(rx_id_i[1] ^ rx_id_i[3] ^ rx_id_i[4] ^ rx_id_i[5]);

  // length coded in identifier bits 5:4 as 2, 2, 4 or 8 bytes
  always_comb begin
    case (s_q.lin_frame_identifier[5:4])
      2'h2:    id_len = 8'h04;
      2'h3:    id_len = 8'h08;
      default: id_len = 8'h02;
    endcase
  end

  assign sum9 = {1'b0, s_q.csum} + {1'b0, ck_data_i};

  // read mux; the key field never comes back
  always_comb begin
    rmux = `ULW_RST_VAL;
    hit = 1'b1;
    case (paddr_i)
      `ULW_OFF_MODE:  rmux = s_q.mode;
      `ULW_OFF_BRGR:  rmux[`ULW_BRGR_W-1:0] = s_q.brgr;
      `ULW_OFF_RX_TIMEOUT_REGISTER:  rmux[`ULW_TO_W-1:0] = s_q.rx_timeout_register;
      `ULW_OFF_TTGR:  rmux[`ULW_TTGR_W-1:0] = s_q.ttgr;
      `ULW_OFF_LINMR: rmux[`ULW_LINMR_W-1:0] = s_q.linmr;
      `ULW_OFF_LIN_FRAME_IDENTIFIER: rmux[`ULW_ID_W-1:0] = s_q.lin_frame_identifier;
      `ULW_OFF_WRITE_GUARD_MODE:  rmux[`ULW_WP_EN] = s_q.guard_enable;
      `ULW_OFF_WRITE_GUARD_STATUS: begin
        rmux[`ULW_WS_VS] = s_q.guard_violation_flag;
        rmux[`ULW_WS_SRC_HI:`ULW_WS_SRC_LO] = s_q.wpsrc;
      end
      `ULW_OFF_VER:   rmux = VERSION_ID;
      default:        hit = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;

    // bus handshake
    s_d.rdy = acc & ~s_q.rdy;
    if (acc && !s_q.rdy) begin
      s_d.rdata = rmux;
      s_d.err = ~hit;
    end

    // register writes take effect at the completing edge
    if (wr_done) begin
      case (paddr_i)
        `ULW_OFF_MODE: begin
          if (!s_q.guard_enable) begin
            s_d.mode = pwdata_i;
          end
        end
        `ULW_OFF_BRGR: begin
          if (!s_q.guard_enable) begin
            s_d.brgr = pwdata_i[`ULW_BRGR_W-1:0];
          end
        end
        `ULW_OFF_RX_TIMEOUT_REGISTER: begin
          if (!s_q.guard_enable) begin
            s_d.rx_timeout_register = pwdata_i[`ULW_TO_W-1:0];
          end
        end
        `ULW_OFF_TTGR: begin
          if (!s_q.guard_enable) begin
            s_d.ttgr = pwdata_i[`ULW_TTGR_W-1:0];
          end
        end
        `ULW_OFF_LINMR: begin
          s_d.linmr = pwdata_i[`ULW_LINMR_W-1:0];
        end
        `ULW_OFF_LIN_FRAME_IDENTIFIER: begin
          if (master) begin
            s_d.lin_frame_identifier = pwdata_i[`ULW_ID_W-1:0];
          end
        end
        `ULW_OFF_WRITE_GUARD_MODE: begin
          if (pwdata_i[`ULW_WP_KEY_HI:`ULW_WP_KEY_LO] == `ULW_WP_KEY) begin
            s_d.guard_enable = pwdata_i[`ULW_WP_EN];
          end
        end
        default: begin
        end
      endcase
    end

    // status read clears; a violation in the same cycle would win
    if (rd_done && paddr_i == `ULW_OFF_WRITE_GUARD_STATUS) begin
      s_d.guard_violation_flag = 1'b0;
      s_d.wpsrc = '0;
    end
    if (wr_done && guarded && s_q.guard_enable) begin
      s_d.guard_violation_flag = 1'b1;
      s_d.wpsrc = {8'h00, paddr_i};
    end

    // slave keeps the last identifier seen on the line
    if (!master && rx_id_valid_i) begin
      s_d.lin_frame_identifier = rx_id_i;
      s_d.perr = ~s_q.linmr[`ULW_LM_ID_PARITY_OFF] & (rx_par != rx_id_i[7:6]);
    end

    // enhanced sum starts from the protected id, classic from zero
    if (ck_clear_i) begin
      s_d.csum = s_q.linmr[`ULW_LM_CHECKSUM_KIND] ? 8'h00 : prot_id;
    end else if (ck_valid_i) begin
      s_d.csum = sum9[7:0] + {7'h00, sum9[8]};
    end

    // fixed divide by eight
    s_d.div = s_q.div + 3'h1;
    s_d.tick = (s_q.div == 3'(`ULW_CLK_DIV - 1));

    // time-out reloads on activity and counts bit periods down
    s_d.tohit = 1'b0;
    if (rx_active_i) begin
      s_d.tocnt = s_q.rx_timeout_register;
    end else if (bit_tick_i && s_q.tocnt != '0) begin
      s_d.tocnt = s_q.tocnt - 17'h00001;
      s_d.tohit = (s_q.tocnt == 17'h00001);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.rdata;
  assign pready_o = s_q.rdy;
  assign pslverr_o = s_q.rdy & s_q.err;
  assign lin_master_o = master;
  assign id_tx_o = prot_id;
  assign id_perr_o = s_q.perr;

  // length field plus one covers 1 to 256 bytes
  assign resp_len_o = s_q.linmr[`ULW_LM_DLM]
                    ? {1'b0, id_len}
                    : {1'b0, s_q.linmr[`ULW_LM_DLC_HI:`ULW_LM_DLC_LO]} + 9'h001;

  // reserved node action code neither sends nor receives
  assign tx_resp_o = (node_action == ulw_pkg::ULW_NODE_ACTION_PUBLISH);
  assign rx_resp_o = (node_action == ulw_pkg::ULW_NODE_ACTION_SUBSCRIBE);

  assign chk_en_o = ~s_q.linmr[`ULW_LM_CHECKSUM_OFF];
  assign chk_classic_o = s_q.linmr[`ULW_LM_CHECKSUM_KIND];
  assign checksum_o = ~s_q.csum;
  assign rx_timeout_o = s_q.tohit;
  assign div_tick_o = s_q.tick;
  assign cd_o = s_q.brgr[15:0];
  assign fp_o = s_q.brgr[18:16];
  assign guard_time_o = s_q.ttgr;

endmodule

/* src/ulw_params.svh */
// register map, field positions, reset values and timing counts of the lin/guard block
`ifndef ULW_PARAMS_SVH
`define ULW_PARAMS_SVH
`define ULW_OFF_MODE   8'h04
`define ULW_OFF_BRGR   8'h20
`define ULW_OFF_RX_TIMEOUT_REGISTER   8'h24
`define ULW_OFF_TTGR   8'h28
`define ULW_OFF_LINMR  8'h54
`define ULW_OFF_LIN_FRAME_IDENTIFIER  8'h58
`define ULW_OFF_WRITE_GUARD_MODE   8'he4
`define ULW_OFF_WRITE_GUARD_STATUS   8'he8
`define ULW_OFF_VER    8'hfc
`define ULW_MODE_W     32
`define ULW_MR_LINM    0
`define ULW_BRGR_W     19
`define ULW_TO_W       17
`define ULW_TTGR_W     8
`define ULW_LINMR_W    17
`define ULW_LM_NODE_ACTION_HI 1
`define ULW_LM_NODE_ACTION_LO 0
`define ULW_LM_ID_PARITY_OFF  2
`define ULW_LM_CHECKSUM_OFF  3
`define ULW_LM_CHECKSUM_KIND  4
`define ULW_LM_DLM     5
`define ULW_LM_DLC_HI  15
`define ULW_LM_DLC_LO  8
`define ULW_ID_W       8
`define ULW_WP_KEY_HI  31
`define ULW_WP_KEY_LO  8
`define ULW_WP_KEY     24'h555341
`define ULW_WP_EN      0
`define ULW_WS_VS      0
`define ULW_WS_SRC_HI  23
`define ULW_WS_SRC_LO  8
`define ULW_SRC_W      16
`define ULW_RST_VAL    32'h00000000
`define ULW_VERSION    32'h00000123
`define ULW_CLK_DIV    8
`define ULW_DIV_W      3
`define ULW_LEN_W      9
`endif

/* src/ulw_pkg.sv */
// types shared by the lin frame configuration and write guard block
`include "ulw_params.svh"
package ulw_pkg;
  typedef enum logic [1:0] {
    ULW_NODE_ACTION_PUBLISH,
    ULW_NODE_ACTION_SUBSCRIBE,
    ULW_NODE_ACTION_IGNORE,
    ULW_NODE_ACTION_RESERVED
  } ulw_node_action_e;

  typedef struct packed {
    logic [`ULW_MODE_W-1:0]  mode;
    logic [`ULW_BRGR_W-1:0]  brgr;
    logic [`ULW_TO_W-1:0]    rx_timeout_register;
    logic [`ULW_TTGR_W-1:0]  ttgr;
    logic [`ULW_LINMR_W-1:0] linmr;
    logic [`ULW_ID_W-1:0]    lin_frame_identifier;
    logic                    guard_enable;
    logic                    guard_violation_flag;
    logic [`ULW_SRC_W-1:0]   wpsrc;
    logic                    rdy;
    logic                    err;
    logic [31:0]             rdata;
    logic [`ULW_DIV_W-1:0]   div;
    logic                    tick;
    logic [`ULW_TO_W-1:0]    tocnt;
    logic                    tohit;
    logic [`ULW_ID_W-1:0]    csum;
    logic                    perr;
  } ulw_state_s;
endpackage
